// >>> common/dod_pkg.sv
// constants and types for the opcode decoder
package dod_pkg;

	// instruction word field positions
	localparam int UB_MSB   = 15;
	localparam int UB_LSB   = 8;
	localparam int UN_LSB   = 12;
	localparam int P12_LSB  = 4;
	localparam int P6_LSB   = 10;
	localparam int SH3_MSB  = 10;
	localparam int SH4_MSB  = 11;
	localparam int LN_MSB   = 3;
	localparam int LN_LSB   = 0;
	localparam int ACC_HIGH_BIT = 11;
	localparam int ADDR_IND_BIT = 7;
	localparam int ADDR_FLD_MSB = 6;

	// full-word opcodes
	localparam logic [15:0] OPC_POP_ACC  = 16'hBE32;
	localparam logic [15:0] OPC_PUSH_ACC = 16'hBE3C;
	localparam logic [15:0] OPC_SUB_EXIT = 16'hEF00;
	localparam logic [15:0] OPC_XOR_SH16 = 16'hBE83;

	// upper bytes, nibbles and prefixes
	localparam logic [7:0]  UB_STACK_TO_MEM = 8'h8A;
	localparam logic [7:0]  UB_MEM_TO_STACK = 8'h76;
	localparam logic [7:0]  UB_REPEAT_IMM   = 8'hBB;
	localparam logic [7:0]  UB_REPEAT_MEM   = 8'h0B;
	localparam logic [3:0]  UN_STORE_ACC    = 4'h9;
	localparam logic [7:0]  UB_AUX_DEC      = 8'h7C;
	localparam logic [11:0] PF_STATUS_SET   = 12'hBE4;
	localparam logic [7:0]  UB_PROD_SHIFT   = 8'hBF;
	localparam logic [7:0]  UB_SQR_ACC      = 8'h52;
	localparam logic [7:0]  UB_SQR_SUB      = 8'h53;
	localparam logic [7:0]  UB_STW_FIRST    = 8'h8E;
	localparam logic [7:0]  UB_STW_SECOND   = 8'h8F;
	localparam logic [7:0]  UB_LONG_STORE   = 8'hAE;
	localparam logic [11:0] PF_SUB_LONG     = 12'hBFA;
	localparam logic [11:0] PF_XOR_SHIFT    = 12'hBFD;
	localparam logic [3:0]  UN_SUB_SHIFT    = 4'h3;
	localparam logic [7:0]  UB_SUB_IMM      = 8'hBA;
	localparam logic [7:0]  UB_SUB_HIGH     = 8'h65;
	localparam logic [7:0]  UB_SUB_BORROW   = 8'h64;
	localparam logic [7:0]  UB_SUB_NOSEXT   = 8'h66;
	localparam logic [7:0]  UB_SUB_VAR      = 8'h67;
	localparam logic [7:0]  UB_CLR_LOAD_RND = 8'h68;
	localparam logic [5:0]  PF_COND_EXIT    = 6'h3B;

	// status-set target nibbles
	localparam logic [3:0] SET_PROG_BLOCK = 4'h5;
	localparam logic [3:0] SET_CARRY      = 4'hF;
	localparam logic [3:0] SET_INT_DIS    = 4'h1;
	localparam logic [3:0] SET_OVF_MODE   = 4'h3;
	localparam logic [3:0] SET_TEST_FLAG  = 4'hB;
	localparam logic [3:0] SET_EXT_FLAG   = 4'hD;
	localparam logic [3:0] SET_SIGN_EXT   = 4'h7;

	// word and cycle counts
	localparam logic [1:0] W_ONE    = 2'h1;
	localparam logic [1:0] W_TWO    = 2'h2;
	localparam logic [2:0] CYC_ONE  = 3'h1;
	localparam logic [2:0] CYC_TWO  = 3'h2;
	localparam logic [2:0] CYC_FOUR = 3'h4;

	// register map and fields
	localparam int          REG_ADDR_W   = 8;
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam logic [7:0]  REG_IMM      = 8'h08;
	localparam logic [7:0]  REG_COUNT    = 8'h0C;
	localparam int          CTRL_EN_BIT  = 0;
	localparam int          CTRL_CLR_BIT = 1;
	localparam int          ST_OP_LSB    = 0;
	localparam int          ST_WORDS_LSB = 8;
	localparam int          ST_CYC_LSB   = 12;
	localparam int          ST_PEND_BIT  = 16;
	localparam int          ST_EN_BIT    = 17;
	localparam logic [2:0]  HSIZE_WORD   = 3'h2;
	localparam logic [15:0] COUNT_ONE    = 16'h0001;

	typedef enum logic [4:0] {
		OP_UNKNOWN       = 5'h00, OP_POP_TO_ACC     = 5'h01,
		OP_STACK_TO_MEM  = 5'h02, OP_MEM_TO_STACK   = 5'h03,
		OP_PUSH_ACC      = 5'h04, OP_SUB_EXIT       = 5'h05,
		OP_COND_EXIT     = 5'h06, OP_REPEAT_IMM     = 5'h07,
		OP_REPEAT_MEM    = 5'h08, OP_STORE_HIGH     = 5'h09,
		OP_STORE_LOW     = 5'h0A, OP_AUX_DEC_IMM    = 5'h0B,
		OP_STATUS_SET    = 5'h0C, OP_PROD_SHIFT     = 5'h0D,
		OP_SQR_ACC       = 5'h0E, OP_SQR_SUB        = 5'h0F,
		OP_STW_FIRST     = 5'h10, OP_STW_SECOND     = 5'h11,
		OP_LONG_STORE    = 5'h12, OP_SUB_LONG_IMM   = 5'h13,
		OP_SUB_SHIFT     = 5'h14, OP_SUB_IMM8       = 5'h15,
		OP_SUB_HIGH      = 5'h16, OP_SUB_BORROW     = 5'h17,
		OP_SUB_NO_SEXT   = 5'h18, OP_SUB_VAR_SHIFT  = 5'h19,
		OP_XOR_IMM_SH16  = 5'h1A, OP_XOR_IMM_SHIFT  = 5'h1B,
		OP_CLR_LOAD_RND  = 5'h1C
	} dod_op_t;

	typedef enum logic {
		FSM_IDLE     = 1'b0,
		FSM_WAIT_IMM = 1'b1
	} dod_fsm_t;

	typedef struct packed {
		logic       indirect;
		logic [6:0] field;
	} dod_addr_t;

	typedef struct packed {
		dod_op_t    op;
		logic [1:0] words;
		logic [2:0] cycles;
		logic       acc_high;
		logic [3:0] shift;
		logic [3:0] status_sel;
		logic [7:0] imm8;
		dod_addr_t  addr;
		logic [15:0] imm16;
	} dod_dec_t;

	typedef struct packed {
		dod_fsm_t    fsm;
		logic        ctrl_en;
		logic        fetch_ready;
		logic        dec_valid;
		dod_dec_t    dec;
		dod_dec_t    pend;
		logic [15:0] last_imm;
		logic [15:0] count;
		logic        wr_pend;
		logic [7:0]  wr_addr;
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} dod_state_t;

	localparam dod_state_t STATE_RST = '{
		fsm: FSM_IDLE, ctrl_en: 1'b1, fetch_ready: 1'b1, hreadyout: 1'b1, default: '0};

endpackage : dod_pkg

// >>> dv/dod_fetch_model.sv
// fetch-side partner model: offers queued program words, holds each until taken
`timescale 1ns/1ps
`default_nettype none
module dod_fetch_model
	import dod_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        fetch_ready,
	input  wire logic        slow,
	output var  logic        fetch_valid,
	output var  logic [15:0] fetch_word,
	output var  logic        cond_taken
);
	logic [16:0] q[$];
	logic [1:0]  gap_q = 2'h0;

	initial
	begin
		fetch_valid = 1'b0;
		fetch_word = 16'h0000;
		cond_taken = 1'b0;
	end

	// a released word line toggles every cycle so stale data never looks valid
	always @(posedge clock)
	begin
		gap_q <= gap_q + 2'h1;
		if (!rst_n)
			fetch_valid <= 1'b0;
		else if (!(fetch_valid && !fetch_ready))
		begin
			if (fetch_valid)
				void'(q.pop_front());
			if (q.size() != 0 && (!slow || gap_q == 2'h0))
			begin
				fetch_valid <= 1'b1;
				{cond_taken, fetch_word} <= q[0];
			end
			else
			begin
				fetch_valid <= 1'b0;
				fetch_word <= ~fetch_word;
				cond_taken <= ~cond_taken;
			end
		end
	end
endmodule : dod_fetch_model
`default_nettype wire

// >>> dv/test_dsp_opcode_decode_p_to_z.sv
// self-checking bench for the opcode decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_dsp_opcode_decode_p_to_z
	import dod_pkg::*;
;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        slow = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic        fetch_valid, fetch_ready, cond_taken, dec_valid, hreadyout, hresp;
	logic [15:0] fetch_word;
	logic [31:0] hrdata, rd;
	dod_dec_t    dec;
	int          mismatches = 0;
	int          cmp_count = 0;
	integer      seed = 32'hEA2F;
	logic [33:0] eq[$];
	logic [33:0] last_e, m_e;
	logic [15:0] wq[$];
	logic [15:0] m_w;
	logic [15:0] last_imm = 16'h0000;
	logic [15:0] dir [37] = '{16'hBE32, 16'h8A81, 16'h7605, 16'hBE3C, 16'hEF00, 16'hEC12,
		16'hEDFF, 16'hBB07, 16'h0B81, 16'h9A05, 16'h9305, 16'h7C10, 16'hBE45, 16'hBE4F,
		16'hBE41, 16'hBE43, 16'hBE4B, 16'hBE4D, 16'hBE47, 16'hBE40, 16'hBF12, 16'h5201,
		16'h5302, 16'h8E03, 16'h8F04, 16'hAE05, 16'hBFA3, 16'h3F81, 16'hBA09, 16'h6510,
		16'h6411, 16'h6612, 16'h6713, 16'hBE83, 16'hBFD2, 16'h6814, 16'h0000};

	always #4 clock = ~clock;

	dod_fetch_model fetch_u (.clock(clock), .rst_n(rst_n), .fetch_ready(fetch_ready),
		.slow(slow), .fetch_valid(fetch_valid), .fetch_word(fetch_word), .cond_taken(cond_taken));

	dod_decoder #(.ADDR_W(8)) dut_u (.clock(clock), .rst_n(rst_n), .fetch_valid(fetch_valid),
		.fetch_word(fetch_word), .cond_taken(cond_taken), .fetch_ready(fetch_ready),
		.dec_valid(dec_valid), .dec(dec), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

	// {op, words, cycles}; cycles 0 means the count is not checked
	function automatic logic [9:0] exp_of(input logic [15:0] w, input logic c);
		dod_op_t op;
		op = OP_UNKNOWN;
		case (w[15:8])
			8'h8A: op = OP_STACK_TO_MEM;
			8'h76: op = OP_MEM_TO_STACK;
			8'hBB: op = OP_REPEAT_IMM;
			8'h0B: op = OP_REPEAT_MEM;
			8'h7C: op = OP_AUX_DEC_IMM;
			8'hBF: op = OP_PROD_SHIFT;
			8'h52: op = OP_SQR_ACC;
			8'h53: op = OP_SQR_SUB;
			8'h8E: op = OP_STW_FIRST;
			8'h8F: op = OP_STW_SECOND;
			8'hAE: op = OP_LONG_STORE;
			8'hBA: op = OP_SUB_IMM8;
			8'h65: op = OP_SUB_HIGH;
			8'h64: op = OP_SUB_BORROW;
			8'h66: op = OP_SUB_NO_SEXT;
			8'h67: op = OP_SUB_VAR_SHIFT;
			8'h68: op = OP_CLR_LOAD_RND;
			default: ;
		endcase
		casez (w)
			16'hBE32: op = OP_POP_TO_ACC;
			16'hBE3C: op = OP_PUSH_ACC;
			16'hEF00: return {OP_SUB_EXIT, W_ONE, CYC_FOUR};
			16'b1110_11??_????_????: return {OP_COND_EXIT, W_ONE, c ? CYC_FOUR : CYC_TWO};
			16'hBE83: return {OP_XOR_IMM_SH16, W_TWO, CYC_TWO};
			16'hBFD?: return {OP_XOR_IMM_SHIFT, W_TWO, CYC_TWO};
			16'hBFA?: return {OP_SUB_LONG_IMM, W_TWO, CYC_TWO};
			16'hBE4?: op = (w[3:0] inside {SET_PROG_BLOCK, SET_CARRY, SET_INT_DIS, SET_OVF_MODE,
				SET_TEST_FLAG, SET_EXT_FLAG, SET_SIGN_EXT}) ? OP_STATUS_SET : OP_UNKNOWN;
			16'h9???: op = w[11] ? OP_STORE_HIGH : OP_STORE_LOW;
			16'h3???: op = OP_SUB_SHIFT;
			default: ;
		endcase
		if (op == OP_LONG_STORE)
			return {op, W_TWO, CYC_TWO};
		return {op, W_ONE, CYC_ONE};
	endfunction : exp_of

	// shift field: long forms low nibble, stores three bits, subtract four bits
	function automatic logic [3:0] exp_shift(input logic [15:0] w);
		casez (w)
			16'hBFA?, 16'hBFD?: return w[3:0];
			16'h9???: return {1'b0, w[10:8]};
			16'h3???: return w[11:8];
			default: return 4'h0;
		endcase
	endfunction : exp_shift

	task automatic send(input logic [15:0] w, input logic c, input logic [15:0] w2);
		logic [9:0] e;
		e = exp_of(w, c);
		fetch_u.q.push_back({c, w});
		if (e[4:3] == W_TWO)
		begin
			fetch_u.q.push_back({1'b0, w2});
			last_imm = w2;
		end
		else
			w2 = 16'h0000;
		last_e = {e, w[7:0], w2};
		eq.push_back(last_e);
		wq.push_back(w);
	endtask : send

	always @(posedge clock)
		if (dec_valid === 1'b1)
		begin
			if (eq.size() == 0)
				`CHK(dec_valid, 1'b0)
			else
			begin
				m_e = eq.pop_front();
				m_w = wq.pop_front();
				`CHK(dec.imm8, m_w[7:0])
				`CHK(dec.status_sel, m_w[3:0])
				`CHK(dec.acc_high, m_w[15:12] == 4'h9 && m_w[11])
				`CHK(dec.shift, exp_shift(m_w))
				`CHK(dec.op, m_e[33:29])
				`CHK(dec.words, m_e[28:27])
				if (m_e[26:24] != 3'h0)
					`CHK(dec.cycles, m_e[26:24])
				`CHK(dec.addr, m_e[23:16])
				`CHK(dec.imm16, m_e[15:0])
			end
		end

	task automatic summarize;
		$display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	task automatic wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1)
		begin
			mismatches++;
			summarize();
		end
	endtask : wait_ready

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= HSIZE_WORD;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		r = hrdata;
		`CHK(hresp, 1'b0)
	endtask : ahb

	task automatic rchk(input logic [7:0] a, input logic [31:0] x);
		ahb(1'b0, a, 32'h0, rd);
		`CHK(rd, x)
	endtask : rchk

	task automatic drain(input string name);
		int n;
		n = 0;
		while (eq.size() != 0 && n < 5000)
		begin
			@(posedge clock);
			n++;
		end
		@(posedge clock);
		if (eq.size() != 0)
		begin
			mismatches++;
			summarize();
		end
		$display("test %s done", name);
	endtask : drain

	initial
	begin
		repeat (100000) @(posedge clock);
		mismatches++;
		summarize();
	end

	initial
	begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rchk(REG_CTRL, 32'h0000_0001);
		rchk(REG_STATUS, 32'h0002_0000);
		rchk(REG_IMM, 32'h0);
		rchk(REG_COUNT, 32'h0);
		rchk(8'h10, 32'h0);
		drain("reset");
		foreach (dir[i])
			send(dir[i], i[0], 16'hC000 | 16'(i));
		drain("directed");
		rchk(REG_COUNT, 32'($size(dir)));
		rchk(REG_STATUS, {14'h0, 3'b100, last_e[26:24], 2'b00, last_e[28:27], 3'b000,
			last_e[33:29]});
		rchk(REG_IMM, {16'h0, last_imm});
		for (int k = 0; k < 2; k++)
		begin
			slow <= (k == 0);
			repeat (150)
				send(16'($random(seed)), 1'($random(seed)), 16'($random(seed)));
			drain("random");
		end
		ahb(1'b1, REG_CTRL, 32'h0, rd);
		@(posedge clock);
		`CHK(fetch_ready, 1'b0)
		send(16'hBE32, 1'b0, 16'h0);
		repeat (10) @(posedge clock);
		`CHK(eq.size(), 1)
		ahb(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
		rchk(8'h10, 32'h0);
		ahb(1'b1, REG_CTRL, 32'h3, rd);
		drain("disable");
		rchk(REG_COUNT, 32'h1);
		summarize();
	end
endmodule : test_dsp_opcode_decode_p_to_z
`default_nettype wire

// >>> verilog/dod_decoder.sv
// opcode decoder with fetch handshake and AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RQ1 - word BE32 is one-word one-cycle pop of stack top to low accumulator
// RQ2 - upper byte 8A pops stack top into addressed data memory, 1/1
// RQ3 - upper byte 76 pushes addressed data-memory word onto stack, 1/1
// RQ4 - word BE3C pushes low accumulator onto stack in one cycle
// RQ5 - EF00 returns in four cycles; 1110 11xx conditional return takes 4 or 2
// RQ6 - repeat count from immediate (BB) or data memory (0B), 1/1
// RQ7 - nibble 9 stores accumulator; bit 11 picks half, three bits shift
// RQ8 - upper byte 7C subtracts immediate from current auxiliary register
// RQ9 - prefix BE4 sets a status bit chosen by the low nibble
// RQ10 - other BF words set the product output shift mode, one cycle
// RQ11 - upper bytes 52 and 53 square and accumulate or subtract
// RQ12 - upper bytes 8E and 8F store first or second status word
// RQ13 - upper byte AE stores the following constant word, two words two cycles
// RQ14 - BFA plus shift nibble subtracts shifted long immediate, 2/2
// RQ15 - nibble 3 subtracts operand shifted by the next nibble, 1/1
// RQ16 - BA subtracts short immediate; 65 subtracts from high accumulator
// RQ17 - upper byte 64 subtracts operand with borrow
// RQ18 - upper byte 66 subtracts without sign extension
// RQ19 - upper byte 67 subtracts with shift held in temp multiplicand register
// RQ20 - BE83 xors constant shifted 16; BFD plus nibble xors shifted constant
// RQ21 - upper byte 68 clears low half and loads high half rounded
// RQ22 - low address byte decodes as direct or indirect descriptor
// RQ23 - second word of two-word ops is held as the immediate operand
module dod_decoder
	import dod_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              fetch_valid,
	input  wire logic [15:0]       fetch_word,
	input  wire logic              cond_taken,
	output var  logic              fetch_ready,
	output var  logic              dec_valid,
	output var  dod_dec_t          dec,
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic              hready,
	input  wire logic [31:0]       hwdata,
	output var  logic              hreadyout,
	output var  logic [31:0]       hrdata,
	output var  logic              hresp
);

	if (ADDR_W < REG_ADDR_W || ADDR_W > 32)
	begin : g_bad_addr_w
		$error("ADDR_W must lie between 8 and 32");
	end

	dod_state_t s_q;
	dod_state_t s_d;
	logic       take;
	logic       pending;
	logic       accept;

	assign take    = fetch_valid && s_q.fetch_ready;
	assign pending = (s_q.fsm == FSM_WAIT_IMM);
	assign accept  = hsel && hready && htrans[1];

	// classify one program word; the second word of a pair is not seen here
	function automatic dod_dec_t decode_word(input logic [15:0] w, input logic taken);
		dod_dec_t   d;
		logic [7:0] ub;
		logic [3:0] un;
		logic [3:0] ln;
		d             = '0;
		ub            = w[UB_MSB:UB_LSB];
		un            = w[UB_MSB:UN_LSB];
		ln            = w[LN_MSB:LN_LSB];
		d.op          = OP_UNKNOWN;
		d.words       = W_ONE;
		d.cycles      = CYC_ONE;
		d.imm8        = w[UB_LSB-1:0];
		d.status_sel  = ln;
		d.addr.indirect = w[ADDR_IND_BIT]; // RQ22
		d.addr.field  = w[ADDR_FLD_MSB:0]; // RQ22
		if (w == OPC_POP_ACC)
			d.op = OP_POP_TO_ACC; // RQ1
		else if (w == OPC_PUSH_ACC)
			d.op = OP_PUSH_ACC; // RQ4
		else if (w == OPC_SUB_EXIT)
		begin
			d.op     = OP_SUB_EXIT; // RQ5
			d.cycles = CYC_FOUR;
		end
		else if (w[UB_MSB:P6_LSB] == PF_COND_EXIT)
		begin
			d.op     = OP_COND_EXIT; // RQ5
			d.cycles = taken ? CYC_FOUR : CYC_TWO;
		end
		else if (w == OPC_XOR_SH16)
		begin
			d.op    = OP_XOR_IMM_SH16; // RQ20
			d.words = W_TWO;
			d.cycles = CYC_TWO;
		end
		else if (w[UB_MSB:P12_LSB] == PF_XOR_SHIFT)
		begin
			d.op    = OP_XOR_IMM_SHIFT; // RQ20
			d.shift = ln;
			d.words = W_TWO;
			d.cycles = CYC_TWO;
		end
		else if (w[UB_MSB:P12_LSB] == PF_SUB_LONG)
		begin
			d.op    = OP_SUB_LONG_IMM; // RQ14
			d.shift = ln;
			d.words = W_TWO;
			d.cycles = CYC_TWO;
		end
		else if (w[UB_MSB:P12_LSB] == PF_STATUS_SET)
		begin
			// only the seven listed targets are valid
			case (ln) // RQ9
				SET_PROG_BLOCK, SET_CARRY, SET_INT_DIS, SET_OVF_MODE,
				SET_TEST_FLAG, SET_EXT_FLAG, SET_SIGN_EXT:
					d.op = OP_STATUS_SET;
				default:
					d.op = OP_UNKNOWN;
			endcase
		end
		else if (un == UN_STORE_ACC)
		begin
			d.acc_high = w[ACC_HIGH_BIT]; // RQ7
			d.shift    = {1'b0, w[SH3_MSB:UB_LSB]};
			d.op       = w[ACC_HIGH_BIT] ? OP_STORE_HIGH : OP_STORE_LOW;
		end
		else if (un == UN_SUB_SHIFT)
		begin
			d.op    = OP_SUB_SHIFT; // RQ15
			d.shift = w[SH4_MSB:UB_LSB];
		end
		else
		begin
			case (ub)
				UB_STACK_TO_MEM: d.op = OP_STACK_TO_MEM; // RQ2
				UB_MEM_TO_STACK: d.op = OP_MEM_TO_STACK; // RQ3
				UB_REPEAT_IMM:   d.op = OP_REPEAT_IMM; // RQ6
				UB_REPEAT_MEM:   d.op = OP_REPEAT_MEM; // RQ6
				UB_AUX_DEC:      d.op = OP_AUX_DEC_IMM; // RQ8
				UB_PROD_SHIFT:   d.op = OP_PROD_SHIFT; // RQ10
				UB_SQR_ACC:      d.op = OP_SQR_ACC; // RQ11
				UB_SQR_SUB:      d.op = OP_SQR_SUB; // RQ11
				UB_STW_FIRST:    d.op = OP_STW_FIRST; // RQ12
				UB_STW_SECOND:   d.op = OP_STW_SECOND; // RQ12
				UB_SUB_IMM:      d.op = OP_SUB_IMM8; // RQ16
				UB_SUB_HIGH:     d.op = OP_SUB_HIGH; // RQ16
				UB_SUB_BORROW:   d.op = OP_SUB_BORROW; // RQ17
				UB_SUB_NOSEXT:   d.op = OP_SUB_NO_SEXT; // RQ18
				UB_SUB_VAR:      d.op = OP_SUB_VAR_SHIFT; // RQ19
				UB_CLR_LOAD_RND: d.op = OP_CLR_LOAD_RND; // RQ21
				UB_LONG_STORE:
				begin
					d.op     = OP_LONG_STORE; // RQ13
					d.words  = W_TWO;
					d.cycles = CYC_TWO;
				end
				default:         d.op = OP_UNKNOWN;
			endcase
		end
		return d;
	endfunction : decode_word

	function automatic logic [31:0] read_reg(input logic [7:0] a, input dod_state_t s);
		logic [31:0] r;
		r = '0;
		case (a)
			REG_CTRL:
				r[CTRL_EN_BIT] = s.ctrl_en;
			REG_STATUS:
			begin
				r[ST_OP_LSB +: $bits(dod_op_t)] = s.dec.op;
				r[ST_WORDS_LSB +: 2]            = s.dec.words;
				r[ST_CYC_LSB +: 3]              = s.dec.cycles;
				r[ST_PEND_BIT]                  = (s.fsm == FSM_WAIT_IMM);
				r[ST_EN_BIT]                    = s.ctrl_en;
			end
			REG_IMM:
				r[15:0] = s.last_imm;
			REG_COUNT:
				r[15:0] = s.count;
			default:
				r = '0;
		endcase
		return r;
	endfunction : read_reg

	always_comb
	begin
		dod_dec_t d;
		d           = '0;
		s_d         = s_q;
		s_d.dec_valid = 1'b0;
		s_d.hreadyout = 1'b1;
		s_d.hresp   = 1'b0;

		// register writes land in the data phase
		if (s_q.wr_pend && s_q.wr_addr == REG_CTRL)
		begin
			s_d.ctrl_en = hwdata[CTRL_EN_BIT];
			if (hwdata[CTRL_CLR_BIT])
				s_d.count = '0;
		end
		s_d.wr_pend = accept && hwrite && (hsize == HSIZE_WORD);
		s_d.wr_addr = haddr[REG_ADDR_W-1:0];
		s_d.hrdata  = (accept && !hwrite) ? read_reg(haddr[REG_ADDR_W-1:0], s_q) : '0;

		case (s_q.fsm)
			FSM_IDLE:
			begin
				if (take)
				begin
					d = decode_word(fetch_word, cond_taken);
					if (d.words == W_TWO)
					begin
						s_d.pend = d; // RQ23
						s_d.fsm  = FSM_WAIT_IMM;
					end
					else
					begin
						s_d.dec       = d;
						s_d.dec_valid = 1'b1;
						s_d.count     = s_d.count + COUNT_ONE;
					end
				end
			end
			FSM_WAIT_IMM:
			begin
				if (take)
				begin
					s_d.dec       = s_q.pend;
					s_d.dec.imm16 = fetch_word; // RQ13 RQ14 RQ20 RQ23
					s_d.last_imm  = fetch_word;
					s_d.dec_valid = 1'b1;
					s_d.count     = s_d.count + COUNT_ONE;
					s_d.fsm       = FSM_IDLE;
				end
			end
			default:
				s_d.fsm = FSM_IDLE;
		endcase
		s_d.fetch_ready = s_d.ctrl_en;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			s_q <= STATE_RST;
		else
			s_q <= s_d;
	end

	assign fetch_ready = s_q.fetch_ready;
	assign dec_valid   = s_q.dec_valid;
	assign dec         = s_q.dec;
	assign hreadyout   = s_q.hreadyout;
	assign hrdata      = s_q.hrdata;
	assign hresp       = s_q.hresp;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_single_take;
		take && !pending;
	endsequence

	sequence s_one_cycle_out;
		dec_valid && dec.words == W_ONE && dec.cycles == CYC_ONE;
	endsequence

	property p_pop_acc;
		(s_single_take ##0 fetch_word == OPC_POP_ACC)
			|=> s_one_cycle_out ##0 dec.op == OP_POP_TO_ACC;
	endproperty
	a_pop_acc: assert property (p_pop_acc) else $error("pop to accumulator misdecoded"); // RQ1

	property p_stack_to_mem;
		(s_single_take ##0 fetch_word[UB_MSB:UB_LSB] == UB_STACK_TO_MEM)
			|=> s_one_cycle_out ##0 dec.op == OP_STACK_TO_MEM
			&& {dec.addr.indirect, dec.addr.field} == $past(fetch_word[UB_LSB-1:0]);
	endproperty
	a_stack_to_mem: assert property (p_stack_to_mem) else $error("stack pop to memory wrong"); // RQ2

	property p_mem_to_stack;
		(s_single_take ##0 fetch_word[UB_MSB:UB_LSB] == UB_MEM_TO_STACK)
			|=> s_one_cycle_out ##0 dec.op == OP_MEM_TO_STACK;
	endproperty
	a_mem_to_stack: assert property (p_mem_to_stack) else $error("memory push misdecoded"); // RQ3

	property p_cond_exit;
		(s_single_take ##0 fetch_word[UB_MSB:P6_LSB] == PF_COND_EXIT && fetch_word != OPC_SUB_EXIT)
			|=> dec_valid && dec.op == OP_COND_EXIT
			&& dec.cycles == ($past(cond_taken) ? CYC_FOUR : CYC_TWO);
	endproperty
	a_cond_exit: assert property (p_cond_exit) else $error("conditional return cycles wrong"); // RQ5

	property p_store_acc;
		(s_single_take ##0 fetch_word[UB_MSB:UN_LSB] == UN_STORE_ACC)
			|=> dec_valid && dec.acc_high == $past(fetch_word[ACC_HIGH_BIT])
			&& dec.shift[2:0] == $past(fetch_word[SH3_MSB:UB_LSB]);
	endproperty
	a_store_acc: assert property (p_store_acc) else $error("accumulator store fields wrong"); // RQ7

	property p_status_set;
		(s_single_take ##0 fetch_word == {PF_STATUS_SET, SET_EXT_FLAG})
			|=> dec_valid && dec.op == OP_STATUS_SET && dec.status_sel == SET_EXT_FLAG;
	endproperty
	a_status_set: assert property (p_status_set) else $error("status set misdecoded"); // RQ9

	sequence s_long_first;
		s_single_take ##0 fetch_word[UB_MSB:UB_LSB] == UB_LONG_STORE;
	endsequence

	property p_long_first;
		s_long_first |=> !dec_valid && pending;
	endproperty
	a_long_first: assert property (p_long_first) else $error("long store did not wait"); // RQ13

	property p_second_word;
		(take && pending) |=> dec_valid && dec.words == W_TWO && dec.cycles == CYC_TWO
			&& dec.imm16 == $past(fetch_word) && !pending;
	endproperty
	a_second_word: assert property (p_second_word) else $error("second word not held"); // RQ23

	property p_clr_load;
		(s_single_take ##0 fetch_word[UB_MSB:UB_LSB] == UB_CLR_LOAD_RND)
			|=> s_one_cycle_out ##0 dec.op == OP_CLR_LOAD_RND;
	endproperty
	a_clr_load: assert property (p_clr_load) else $error("rounding load misdecoded"); // RQ21

	property p_push_acc;
		(s_single_take ##0 fetch_word == OPC_PUSH_ACC)
			|=> s_one_cycle_out ##0 dec.op == OP_PUSH_ACC;
	endproperty
	a_push_acc: assert property (p_push_acc) else $error("accumulator push misdecoded"); // RQ4

	property p_sub_exit;
		(s_single_take ##0 fetch_word == OPC_SUB_EXIT)
			|=> dec_valid && dec.op == OP_SUB_EXIT && dec.cycles == CYC_FOUR;
	endproperty
	a_sub_exit: assert property (p_sub_exit) else $error("return cycles wrong"); // RQ5

	property p_repeat_imm;
		(s_single_take ##0 fetch_word[UB_MSB:UB_LSB] == UB_REPEAT_IMM)
			|=> s_one_cycle_out ##0 dec.op == OP_REPEAT_IMM
			&& dec.imm8 == $past(fetch_word[UB_LSB-1:0]);
	endproperty
	a_repeat_imm: assert property (p_repeat_imm) else $error("repeat count misdecoded"); // RQ6

	property p_sub_long;
		(s_single_take ##0 fetch_word[UB_MSB:P12_LSB] == PF_SUB_LONG)
			|=> !dec_valid && pending && s_q.pend.op == OP_SUB_LONG_IMM
			&& s_q.pend.shift == $past(fetch_word[LN_MSB:LN_LSB]);
	endproperty
	a_sub_long: assert property (p_sub_long) else $error("long subtract not held"); // RQ14

	property p_sub_shift;
		(s_single_take ##0 fetch_word[UB_MSB:UN_LSB] == UN_SUB_SHIFT)
			|=> s_one_cycle_out ##0 dec.op == OP_SUB_SHIFT
			&& dec.shift == $past(fetch_word[SH4_MSB:UB_LSB]);
	endproperty
	a_sub_shift: assert property (p_sub_shift) else $error("shifted subtract wrong"); // RQ15

	property p_sub_borrow;
		(s_single_take ##0 fetch_word[UB_MSB:UB_LSB] == UB_SUB_BORROW)
			|=> s_one_cycle_out ##0 dec.op == OP_SUB_BORROW;
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow subtract wrong"); // RQ17

	property p_xor_sh16;
		(s_single_take ##0 fetch_word == OPC_XOR_SH16)
			|=> !dec_valid && pending && s_q.pend.op == OP_XOR_IMM_SH16;
	endproperty
	a_xor_sh16: assert property (p_xor_sh16) else $error("xor constant not held"); // RQ20

endmodule : dod_decoder

`default_nettype wire
